// ---- design/ssp_port.sv ----
// Behaviour
// - Data changes on falling clock edges and is sampled on rising edges.
// - Single access is 16 clocks; each further burst byte adds 8 clocks.
// - Bit 0 starts at first falling edge after select falls.
// - First bit zero writes into the device, one reads from it.
// - Read data is driven from the start of bit 8, never earlier.
// - Bits 1 to 7 hold the 7-bit register index.
// - Bits 8 to 15 hold the data byte, most significant bit first.
// - Auto-increment clear keeps the same index for every burst byte.
// - Auto-increment set advances the index by one after each byte.
// - Three-wire select set returns read data on the shared data line.
// - Three-wire mode supports single and burst reads.
// - Calibration registers are reloaded automatically at power-up.
// - Three-wire select is control one bit 0, reset to 0.
// - Auto-increment enable lives in control two and resets enabled.
// - Select high idles the port and, while NRST is high, enables the two-wire interface.
`timescale 1ns/100ps
`default_nettype none
`include "ssp_consts.svh"
module ssp_port #(
   // The identity value is arbitrary.
   parameter logic [7:0] IDENTITY_CODE = 8'h5a
)
(
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic SERIAL_PORT_CLOCK,
   input wire logic CHIP_SELECT_N,
   input wire logic SERIAL_IN_LINE_I,
   output logic SERIAL_IN_LINE_O,
   output logic SERIAL_IN_LINE_OE,
   output logic SERIAL_OUT_LINE_O,
   output logic SERIAL_OUT_LINE_OE,
   output logic TWO_WIRE_ENABLE,
   input wire ssp_pkg::ssp_ro_regs_t RO_REGS,
   input wire logic [15:0] BOOT_CAL,
   output ssp_pkg::ssp_rw_regs_t REG_OUT
);
   import ssp_pkg::*;

   // One group for the system clock, three for the link clock; rise and fall groups are cleared by select, the write group by the NRST hand-off reset.
   ssp_sys_t s;
   ssp_sys_t next_s;
   ssp_rise_t r;
   ssp_rise_t next_r;
   ssp_wr_t w;
   ssp_wr_t next_w;
   ssp_fall_t f;
   ssp_fall_t next_f;
   logic wr_fire;
   logic [7:0] rx_byte;
   logic [7:0] rd_byte;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map helpers.

   // Reserved and unmapped indices read as zero; a flat chain keeps the decode easy to audit.
   function automatic logic [7:0] read_decode(input ssp_rw_regs_t rg, input ssp_ro_regs_t ro,
                                              input logic [6:0] a);
      logic [7:0] d;
      d = '0;
      if (a == `SSP_OFS_INTERRUPT_CONFIG)
      begin
         d = rg.interrupt_config;
      end
      else if (a == `SSP_OFS_THRESHOLD_LOW)
      begin
         d = rg.threshold_low;
      end
      else if (a == `SSP_OFS_THRESHOLD_HIGH)
      begin
         d = rg.threshold_high;
      end
      else if (a == `SSP_OFS_IDENTITY_CODE)
      begin
         d = IDENTITY_CODE;
      end
      else if (a == `SSP_OFS_CONTROL_ONE)
      begin
         d = rg.control_one;
      end
      else if (a == `SSP_OFS_CONTROL_TWO)
      begin
         d = rg.control_two;
      end
      else if (a == `SSP_OFS_CONTROL_THREE)
      begin
         d = rg.control_three;
      end
      else if (a == `SSP_OFS_QUEUE_CONTROL)
      begin
         d = rg.queue_control;
      end
      else if (a == `SSP_OFS_PRESSURE_REF_XLOW)
      begin
         d = rg.pressure_ref_xlow;
      end
      else if (a == `SSP_OFS_PRESSURE_REF_LOW)
      begin
         d = rg.pressure_ref_low;
      end
      else if (a == `SSP_OFS_PRESSURE_REF_HIGH)
      begin
         d = rg.pressure_ref_high;
      end
      else if (a == `SSP_OFS_OFFSET_COMP_LOW)
      begin
         d = rg.offset_comp_low;
      end
      else if (a == `SSP_OFS_OFFSET_COMP_HIGH)
      begin
         d = rg.offset_comp_high;
      end
      else if (a == `SSP_OFS_RESOLUTION_CONFIG)
      begin
         d = rg.resolution_config;
      end
      else if (a == `SSP_OFS_IRQ_SOURCE)
      begin
         d = ro.irq_source;
      end
      else if (a == `SSP_OFS_QUEUE_STATE)
      begin
         d = ro.queue_state;
      end
      else if (a == `SSP_OFS_SAMPLE_STATUS)
      begin
         d = ro.sample_status;
      end
      else if (a == `SSP_OFS_PRESSURE_OUT_XLOW)
      begin
         d = ro.pressure_out_xlow;
      end
      else if (a == `SSP_OFS_PRESSURE_OUT_LOW)
      begin
         d = ro.pressure_out_low;
      end
      else if (a == `SSP_OFS_PRESSURE_OUT_HIGH)
      begin
         d = ro.pressure_out_high;
      end
      else if (a == `SSP_OFS_TEMP_OUT_LOW)
      begin
         d = ro.temp_out_low;
      end
      else if (a == `SSP_OFS_TEMP_OUT_HIGH)
      begin
         d = ro.temp_out_high;
      end
      else if (a == `SSP_OFS_FILTER_RESET)
      begin
         d = ro.filter_reset;
      end
      return d;
   endfunction : read_decode

   function automatic ssp_map_t build_map(input ssp_rw_regs_t rg, input ssp_ro_regs_t ro);
      ssp_map_t m;
      for (int i = 0; i < `SSP_MAP_DEPTH; i++)
      begin
         m[i] = read_decode(rg, ro, 7'(i));
      end
      return m;
   endfunction : build_map

   // Only writable offsets are decoded; read-only, reserved and unmapped ones fall through untouched.
   function automatic ssp_rw_regs_t apply_write(input ssp_rw_regs_t rg, input logic [6:0] a,
                                                input logic [7:0] d);
      ssp_rw_regs_t o;
      o = rg;
      if (a == `SSP_OFS_INTERRUPT_CONFIG) o.interrupt_config = d;
      else if (a == `SSP_OFS_THRESHOLD_LOW) o.threshold_low = d;
      else if (a == `SSP_OFS_THRESHOLD_HIGH) o.threshold_high = d;
      else if (a == `SSP_OFS_CONTROL_ONE) o.control_one = d;
      else if (a == `SSP_OFS_CONTROL_TWO) o.control_two = d;
      else if (a == `SSP_OFS_CONTROL_THREE) o.control_three = d;
      else if (a == `SSP_OFS_QUEUE_CONTROL) o.queue_control = d;
      else if (a == `SSP_OFS_PRESSURE_REF_XLOW) o.pressure_ref_xlow = d;
      else if (a == `SSP_OFS_PRESSURE_REF_LOW) o.pressure_ref_low = d;
      else if (a == `SSP_OFS_PRESSURE_REF_HIGH) o.pressure_ref_high = d;
      else if (a == `SSP_OFS_OFFSET_COMP_LOW) o.offset_comp_low = d;
      else if (a == `SSP_OFS_OFFSET_COMP_HIGH) o.offset_comp_high = d;
      else if (a == `SSP_OFS_RESOLUTION_CONFIG) o.resolution_config = d;
      return o;
   endfunction : apply_write

   ////////////////////////////////////////////////////////////////////////////////
   // System clock domain: register storage, write intake and read snapshot.

   always_comb
   begin
      next_s = s;
      next_s.cs_meta = CHIP_SELECT_N;
      next_s.cs_sync = s.cs_meta;
      next_s.tg_meta = w.wr_toggle;
      next_s.tg_sync = s.tg_meta;
      // The hand-off reset lasts only while NRST is low, when the link clock is parked.
      next_s.link_rst = 1'b0;
      next_s.two_wire_en = s.cs_sync;
      if (!s.booted)
      begin
         // Calibration is taken in the first cycle after reset release, never under reset itself.
         next_s.booted = 1'b1;
         next_s.regs.offset_comp_low = BOOT_CAL[7:0];
         next_s.regs.offset_comp_high = BOOT_CAL[15:8];
      end
      if (s.tg_sync != s.tg_seen)
      begin
         // The link side holds address and byte steady for a whole byte time after toggling.
         next_s.tg_seen = s.tg_sync;
         next_s.regs = apply_write(next_s.regs, w.wr_addr, w.write_byte);
      end
      // The snapshot is frozen while a frame runs, so the link clock never sees a moving value.
      // Limitation: writes made within a frame reach reads and mode bits only in the next frame.
      if (s.cs_sync)
      begin
         next_s.snap = build_map(next_s.regs, RO_REGS);
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         s <= '0;
         // Select counts as idle under reset, so release shows no false frame start.
         s.cs_meta <= 1'b1;
         s.cs_sync <= 1'b1;
         s.link_rst <= 1'b1;
         s.regs.control_one <= `SSP_RST_DEFAULT;
         s.regs.control_two <= `SSP_RST_CONTROL_TWO;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign REG_OUT = s.regs;
   assign TWO_WIRE_ENABLE = s.two_wire_en;

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain, rising edge: header capture and data bytes.

   assign rx_byte = {r.shift, SERIAL_IN_LINE_I};
   // Only the last bit of a data byte completes a write; a cut byte at frame end is dropped.
   assign wr_fire = (r.phase == PH_DATA) && (r.cnt == `SSP_LAST_BIT) && !r.rw;

   always_comb
   begin
      next_r = r;
      next_r.shift = rx_byte[6:0];
      next_r.cnt = r.cnt + 3'h1;
      case (r.phase)
         PH_HEADER:
         begin
            if (r.cnt == `SSP_LAST_BIT)
            begin
               next_r.rw = r.shift[6];
               next_r.addr = rx_byte[6:0];
               next_r.phase = PH_DATA;
            end
         end
         PH_DATA:
         begin
            if (r.cnt == `SSP_LAST_BIT)
            begin
               if (s.snap[`SSP_OFS_CONTROL_TWO][`SSP_BIT_AUTO_INC])
               begin
                  next_r.addr = r.addr + `SSP_ADDR_STEP;
               end
               else
               begin
                  next_r.addr = r.addr;
               end
            end
         end
         default:
         begin
            // Two phases only, so this branch catches nothing but unknown values.
            next_r.phase = PH_HEADER;
         end
      endcase
   end

   // A frame always restarts from bit 0 because select high holds this state in reset.
   always_ff @(posedge SERIAL_PORT_CLOCK or posedge CHIP_SELECT_N)
   begin
      if (CHIP_SELECT_N)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain: write hand-off toward the system clock.

   always_comb
   begin
      // Address and byte change only with the toggle, so the system side reads them as a pair.
      next_w = w;
      if (wr_fire)
      begin
         next_w.wr_toggle = !w.wr_toggle;
         next_w.wr_addr = r.addr;
         next_w.write_byte = rx_byte;
      end
   end

   // Not reset by select, so a toggle late in a frame is not undone when select rises.
   always_ff @(posedge SERIAL_PORT_CLOCK or posedge s.link_rst)
   begin
      if (s.link_rst)
      begin
         w <= '0;
      end
      else
      begin
         w <= next_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain, falling edge: read data drive.

   // Index and snapshot settle by the rising edge, well before the falling edge reads them.
   assign rd_byte = s.snap[r.addr];

   always_comb
   begin
      // Both lines carry the read bit and only the used line's enable is set; outside a read all four outputs idle at zero.
      next_f = '0;
      if ((r.phase == PH_DATA) && r.rw)
      begin
         next_f.out_bit = rd_byte[`SSP_LAST_BIT - r.cnt];
         next_f.io_bit = rd_byte[`SSP_LAST_BIT - r.cnt];
         if (s.snap[`SSP_OFS_CONTROL_ONE][`SSP_BIT_THREE_WIRE_SELECT])
         begin
            next_f.io_oe = 1'b1;
         end
         else
         begin
            next_f.out_oe = 1'b1;
         end
      end
   end

   // Select high releases both lines at once, even though the serial clock stops with it.
   always_ff @(negedge SERIAL_PORT_CLOCK or posedge CHIP_SELECT_N)
   begin
      if (CHIP_SELECT_N)
      begin
         f <= '0;
      end
      else
      begin
         f <= next_f;
      end
   end

   assign SERIAL_OUT_LINE_O = f.out_bit;
   assign SERIAL_OUT_LINE_OE = f.out_oe;
   assign SERIAL_IN_LINE_O = f.io_bit;
   assign SERIAL_IN_LINE_OE = f.io_oe;
endmodule : ssp_port
`default_nettype wire

// ---- inc/ssp_consts.svh ----
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_MAP_DEPTH 128
`define SSP_OFS_INTERRUPT_CONFIG 7'h0b
`define SSP_OFS_THRESHOLD_LOW 7'h0c
`define SSP_OFS_THRESHOLD_HIGH 7'h0d
`define SSP_OFS_IDENTITY_CODE 7'h0f
`define SSP_OFS_CONTROL_ONE 7'h10
`define SSP_OFS_CONTROL_TWO 7'h11
`define SSP_OFS_CONTROL_THREE 7'h12
`define SSP_OFS_QUEUE_CONTROL 7'h14
`define SSP_OFS_PRESSURE_REF_XLOW 7'h15
`define SSP_OFS_PRESSURE_REF_LOW 7'h16
`define SSP_OFS_PRESSURE_REF_HIGH 7'h17
`define SSP_OFS_OFFSET_COMP_LOW 7'h18
`define SSP_OFS_OFFSET_COMP_HIGH 7'h19
`define SSP_OFS_RESOLUTION_CONFIG 7'h1a
`define SSP_OFS_IRQ_SOURCE 7'h25
`define SSP_OFS_QUEUE_STATE 7'h26
`define SSP_OFS_SAMPLE_STATUS 7'h27
`define SSP_OFS_PRESSURE_OUT_XLOW 7'h28
`define SSP_OFS_PRESSURE_OUT_LOW 7'h29
`define SSP_OFS_PRESSURE_OUT_HIGH 7'h2a
`define SSP_OFS_TEMP_OUT_LOW 7'h2b
`define SSP_OFS_TEMP_OUT_HIGH 7'h2c
`define SSP_OFS_FILTER_RESET 7'h33
`define SSP_RST_DEFAULT 8'h00
`define SSP_RST_CONTROL_TWO 8'h10
`define SSP_BIT_THREE_WIRE_SELECT 0
`define SSP_BIT_AUTO_INC 4
`define SSP_LAST_BIT 3'h7
`define SSP_ADDR_STEP 7'h01
`endif

// ---- inc/ssp_pkg.sv ----
`default_nettype none
package ssp_pkg;
   typedef enum logic {PH_HEADER, PH_DATA} ssp_phase_t;
   typedef struct packed {
      logic [7:0] interrupt_config;
      logic [7:0] threshold_low;
      logic [7:0] threshold_high;
      logic [7:0] control_one;
      logic [7:0] control_two;
      logic [7:0] control_three;
      logic [7:0] queue_control;
      logic [7:0] pressure_ref_xlow;
      logic [7:0] pressure_ref_low;
      logic [7:0] pressure_ref_high;
      logic [7:0] offset_comp_low;
      logic [7:0] offset_comp_high;
      logic [7:0] resolution_config;
   } ssp_rw_regs_t;
   typedef struct packed {
      logic [7:0] irq_source;
      logic [7:0] queue_state;
      logic [7:0] sample_status;
      logic [7:0] pressure_out_xlow;
      logic [7:0] pressure_out_low;
      logic [7:0] pressure_out_high;
      logic [7:0] temp_out_low;
      logic [7:0] temp_out_high;
      logic [7:0] filter_reset;
   } ssp_ro_regs_t;
   typedef logic [127:0][7:0] ssp_map_t;
   typedef struct packed {
      logic cs_meta;
      logic cs_sync;
      logic tg_meta;
      logic tg_sync;
      logic tg_seen;
      logic link_rst;
      logic booted;
      logic two_wire_en;
      ssp_rw_regs_t regs;
      ssp_map_t snap;
   } ssp_sys_t;
   typedef struct packed {
      ssp_phase_t phase;
      logic [2:0] cnt;
      logic [6:0] shift;
      logic rw;
      logic [6:0] addr;
   } ssp_rise_t;
   typedef struct packed {
      logic wr_toggle;
      logic [6:0] wr_addr;
      logic [7:0] write_byte;
   } ssp_wr_t;
   typedef struct packed {
      logic out_bit;
      logic out_oe;
      logic io_bit;
      logic io_oe;
   } ssp_fall_t;
endpackage : ssp_pkg
`default_nettype wire

// ---- dv/ssp_port_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssp_port_properties
(
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic SERIAL_PORT_CLOCK,
   input wire logic CHIP_SELECT_N,
   input wire logic SERIAL_IN_LINE_I,
   input wire logic SERIAL_IN_LINE_OE,
   input wire logic SERIAL_OUT_LINE_OE,
   input wire logic TWO_WIRE_ENABLE,
   input wire ssp_pkg::ssp_rw_regs_t REG_OUT
);
   import ssp_pkg::*;
   logic [3:0] rise_cnt;
   logic rd_frame;
   logic [3:0] idle_cnt;
   wire logic drv = SERIAL_IN_LINE_OE | SERIAL_OUT_LINE_OE;
   // Cleared by select high, as the port's own rise and fall link groups are.
   always_ff @(posedge SERIAL_PORT_CLOCK or posedge CHIP_SELECT_N)
   begin
      if (CHIP_SELECT_N)
         rise_cnt <= 4'h0;
      else if (rise_cnt != 4'h8)
         rise_cnt <= rise_cnt + 4'h1;
   end
   always_ff @(posedge SERIAL_PORT_CLOCK or posedge CHIP_SELECT_N)
   begin
      if (CHIP_SELECT_N)
         rd_frame <= 1'b0;
      else if (rise_cnt == 4'h0)
         rd_frame <= SERIAL_IN_LINE_I;
   end
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST || !CHIP_SELECT_N)
         idle_cnt <= 4'h0;
      else if (idle_cnt != 4'hf)
         idle_cnt <= idle_cnt + 4'h1;
   end
   chk_idle_release: assert property (@(posedge CLK_SYS) CHIP_SELECT_N |-> !drv)
      else $error("data line driven while deselected");
   chk_one_line: assert property (@(posedge CLK_SYS) !(SERIAL_IN_LINE_OE && SERIAL_OUT_LINE_OE))
      else $error("both data lines driven");
   chk_mode_line: assert property (@(posedge CLK_SYS) drv |-> SERIAL_IN_LINE_OE == REG_OUT.control_one[0])
      else $error("read data on wrong line for mode");
   chk_no_early: assert property (@(posedge SERIAL_PORT_CLOCK) disable iff (CHIP_SELECT_N)
      rise_cnt < 4'h8 |-> !drv) else $error("data driven before bit 8");
   chk_read_drive: assert property (@(posedge SERIAL_PORT_CLOCK) disable iff (CHIP_SELECT_N)
      rise_cnt == 4'h8 |-> drv == rd_frame) else $error("data drive does not follow direction bit");
   chk_twe_on: assert property (@(posedge CLK_SYS) disable iff (!NRST)
      $rose(CHIP_SELECT_N) |-> ##[1:5] TWO_WIRE_ENABLE) else $error("two-wire not enabled after deselect");
   chk_twe_off: assert property (@(posedge CLK_SYS) disable iff (!NRST)
      $fell(CHIP_SELECT_N) |-> ##[1:5] !TWO_WIRE_ENABLE) else $error("two-wire still enabled in frame");
   chk_reset_vals: assert property (@(posedge CLK_SYS) !NRST |=>
      REG_OUT.control_two == 8'h10 && REG_OUT.control_one == 8'h00) else $error("control reset value wrong");
   chk_regs_still: assert property (@(posedge CLK_SYS) disable iff (!NRST)
      idle_cnt == 4'hf |-> $stable(REG_OUT)) else $error("registers changed with no write");
   cover property (@(posedge CLK_SYS) $rose(SERIAL_IN_LINE_OE));
   cover property (@(posedge CLK_SYS) $rose(SERIAL_OUT_LINE_OE));
   cover property (@(posedge CLK_SYS) NRST && !$stable(REG_OUT));
endmodule : ssp_port_properties
bind ssp_port ssp_port_properties u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .SERIAL_PORT_CLOCK(SERIAL_PORT_CLOCK),
   .CHIP_SELECT_N(CHIP_SELECT_N), .SERIAL_IN_LINE_I(SERIAL_IN_LINE_I), .SERIAL_IN_LINE_OE(SERIAL_IN_LINE_OE),
   .SERIAL_OUT_LINE_OE(SERIAL_OUT_LINE_OE), .TWO_WIRE_ENABLE(TWO_WIRE_ENABLE), .REG_OUT(REG_OUT));
`default_nettype wire

// ---- dv/ssp_master.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssp_master
(
   output logic serial_port_clock,
   output logic cs_n,
   output logic mosi,
   input wire logic out_line,
   input wire logic io_line
);
   initial
   begin
      serial_port_clock = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // The odd start offset keeps the link edges off the system clock grid.
   task automatic frame(input logic rd, input logic [6:0] idx, input int nb, input logic [31:0] wd,
                        input logic io, output logic [31:0] rdat);
      logic [39:0] sh;
      sh = {rd, idx, wd};
      rdat = 32'h0;
      #3.7 cs_n = 1'b0;
      #40;
      for (int i = 0; i < 8 + 8 * nb; i++)
      begin
         serial_port_clock = 1'b0;
         // A released line must not hold its last level, so it toggles.
         mosi = (rd && i > 7) ? ~mosi : sh[39 - i];
         #40 serial_port_clock = 1'b1;
         rdat = {rdat[30:0], io ? io_line : out_line};
         #40;
      end
      cs_n = 1'b1;
      #100;
   endtask : frame
endmodule : ssp_master
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
   import ssp_pkg::*;
   localparam logic [7:0] ID_CODE = 8'h3c; // Arbitrary value.
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic serial_port_clock, cs_n, mosi, io_o, io_oe, out_o, out_oe, twe, three;
   ssp_ro_regs_t ro = {9{8'ha7}};
   logic [15:0] boot = 16'hc35e;
   ssp_rw_regs_t regs;
   logic [31:0] got;
   int errors = 0;
   int cmp_count = 0;
   always #5 clk_sys = ~clk_sys;
   ssp_port #(.IDENTITY_CODE(ID_CODE)) u_dut (.CLK_SYS(clk_sys), .NRST(nrst), .SERIAL_PORT_CLOCK(serial_port_clock),
      .CHIP_SELECT_N(cs_n), .SERIAL_IN_LINE_I(io_oe ? io_o : mosi), .SERIAL_IN_LINE_O(io_o),
      .SERIAL_IN_LINE_OE(io_oe), .SERIAL_OUT_LINE_O(out_o), .SERIAL_OUT_LINE_OE(out_oe),
      .TWO_WIRE_ENABLE(twe), .RO_REGS(ro), .BOOT_CAL(boot), .REG_OUT(regs));
   // A released output line shows the inverse of its last level; the shared line shows the master.
   ssp_master u_mst (.serial_port_clock(serial_port_clock), .cs_n(cs_n), .mosi(mosi), .out_line(out_oe ? out_o : ~out_o),
      .io_line(io_oe ? io_o : mosi));
   ////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [6:0] idx, input int nb, input logic [31:0] wd);
      u_mst.frame(1'b0, idx, nb, wd, 1'b0, got);
   endtask : wr
   task automatic rd(input logic [6:0] idx, input int nb);
      u_mst.frame(1'b1, idx, nb, 32'h0, three, got);
   endtask : rd
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   initial
   begin
      three = 1'b0;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      check("two-wire idle", 32'h1, {31'h0, twe});
      rd(7'h10, 2);
      check("control burst", 32'h0010, {16'h0, got[15:0]});
      rd(7'h0f, 1);
      check("identity", {24'h0, ID_CODE}, {24'h0, got[7:0]});
      rd(7'h18, 2);
      check("boot cal", {16'h0, boot[7:0], boot[15:8]}, {16'h0, got[15:0]});
      wr(7'h0b, 3, 32'h11223300);
      check("burst write", 32'h112233, {8'h0, regs.interrupt_config, regs.threshold_low, regs.threshold_high});
      wr(7'h14, 4, 32'h01020304);
      check("four byte write", 32'h01020304, {regs.queue_control, regs.pressure_ref_xlow, regs.pressure_ref_low,
         regs.pressure_ref_high});
      wr(7'h12, 1, 32'h5a000000);
      wr(7'h1a, 1, 32'h66000000);
      check("single writes", 32'h5a66, {16'h0, regs.control_three, regs.resolution_config});
      wr(7'h11, 1, 32'h0);
      wr(7'h0c, 2, 32'h44550000);
      check("same index write", 32'h5533, {16'h0, regs.threshold_low, regs.threshold_high});
      rd(7'h0c, 2);
      check("same index read", 32'h5555, {16'h0, got[15:0]});
      wr(7'h28, 1, 32'hff000000);
      check("read-only write", 32'h11553300, {regs.interrupt_config, regs.threshold_low, regs.threshold_high,
         regs.control_two});
      rd(7'h28, 1);
      check("read-only read", 32'ha7, {24'h0, got[7:0]});
      rd(7'h0e, 1);
      check("reserved read", 32'h0, {24'h0, got[7:0]});
      wr(7'h10, 1, 32'h01000000);
      check("three-wire select", 32'h01, {24'h0, regs.control_one});
      three = 1'b1;
      rd(7'h0f, 2);
      check("three-wire burst", {16'h0, ID_CODE, ID_CODE}, {16'h0, got[15:0]});
      rd(7'h0c, 1);
      check("three-wire single", 32'h55, {24'h0, got[7:0]});
      wrap_up();
   end
   initial
   begin
      #200000;
      errors++;
      wrap_up();
   end
endmodule : tb
`default_nettype wire
